// ### sqs_params.svh
`ifndef SQS_PARAMS_SVH
`define SQS_PARAMS_SVH
// register indices, byte address is four times the index
`define SQS_IDX_CTRL1 6'h34
`define SQS_IDX_CTRL2 6'h35
`define SQS_IDX_RESLO 6'h36
`define SQS_IDX_RESHI 6'h37
`define SQS_IDX_EVST 6'h38
`define SQS_IDX_EVMSK 6'h39
// first control register fields
`define SQS_C1_TRIG 0
`define SQS_C1_BUSY 2
`define SQS_C1_DONE 3
`define SQS_C1_CHLO 4
// second control register fields
`define SQS_C2_RESV 0
`define SQS_C2_CONT 1
`define SQS_C2_IRQEN 3
`define SQS_C2_CKSEL 4
// event status bits
`define SQS_EV_DONE 0
`define SQS_EV_RETRIG 1
// reset values
`define SQS_RST_CHAN 3'h0
`define SQS_RST_EVMSK 2'h0
// timing in instruction cycles
`define SQS_SAMPLE_CYC 16
`define SQS_BIT_CYC 4
`define SQS_TAIL_CYC 4
`define SQS_TB_BITS 8
// bus answers
`define SQS_RESP_OKAY 2'h0
`define SQS_RESP_SLVERR 2'h2
`endif

// ### sqs_pkg.sv
package sqs_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_FINISH} sqs_phase_t;
   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } sqs_axi_req_t;
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } sqs_axi_rsp_t;
   typedef struct packed {
      sqs_phase_t phase;
      logic [5:0] cnt;
      logic [3:0] bitIdx;
      logic [9:0] trial;
      logic [9:0] result;
      logic [2:0] channel;
      logic doneFlag;
      logic irqEn;
      logic contEn;
      logic clkSel;
      logic [1:0] evtStat;
      logic [1:0] evtMask;
      logic [7:0] tbDiv;
      logic tbBitQ;
      logic extS1;
      logic extS2;
      logic extQ;
      logic compS1;
      logic compS2;
      logic awHave;
      logic [7:0] awAddr;
      logic wHave;
      logic [7:0] wData;
      logic wStrb0;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [7:0] rData;
      logic [1:0] rResp;
   } sqs_state_t;
endpackage : sqs_pkg

// ### sqs_conv_seq.sv
`include "sqs_params.svh"
// Operation
// - old result kept until trigger, then undefined
// - input connected 16 cycles, then comparison
// - reset, stop or watch halts conversion
// - retrigger at completion leaves done unset
// - irq held while done and enable set
// - timebase trigger stops with oscillator; clear disturbs
// - low eight bits at 36, upper two at 37
// - done bit3, busy bit2, trigger bit0, continuous bit1
// - busy high whole conversion, cleared at end
// - zero write: channel 0, done cleared
// - completion sets done; write zero clears it
// - software trigger only without continuous mode
// - clock select: timebase or external pin
// - about 60 cycles, MSB first into result
module sqs_conv_seq import sqs_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // register bus
   input wire sqs_axi_req_t axiReq,
   output sqs_axi_rsp_t axiRsp,
   // analog front end
   output logic [2:0] channelSel,
   output logic sampleConnect,
   output logic [9:0] trialCode,
   input wire logic compBit,
   // trigger sources and power modes
   input wire logic extTrigPin,
   input wire logic mainOscRun,
   input wire logic tbClear,
   input wire logic haltReq,
   // interrupt
   output logic convIrqLine
);
   sqs_state_t s;
   sqs_state_t n;
   logic wrEn;
   logic wrOk;
   logic [5:0] wIdx;
   logic [5:0] rIdx;
   logic wrCtrl1;
   logic swTrig;
   logic tbRise;
   logic extRise;
   logic contTrig;
   logic trig;
   logic finishing;
   logic lastBit;
   logic [7:0] rdVal;
   logic rdOk;
   logic awHs;
   logic wHs;
   logic arHs;

   assign wIdx = s.awAddr[7:2];
   assign rIdx = axiReq.araddr[7:2];
   assign wrEn = s.awHave & s.wHave & ~s.bValid;
   assign wrOk = wrEn & (s.awAddr[1:0] == 2'h0) & s.wStrb0;
   assign wrCtrl1 = wrOk & (wIdx == `SQS_IDX_CTRL1);
   assign awHs = axiReq.awvalid & axiRsp.awready;
   assign wHs = axiReq.wvalid & axiRsp.wready;
   assign arHs = axiReq.arvalid & axiRsp.arready;

   // timebase edge only while the oscillator runs
   assign tbRise = s.tbDiv[`SQS_TB_BITS-1] & ~s.tbBitQ;
   assign extRise = s.extS2 & ~s.extQ;
   assign contTrig = s.contEn & (s.clkSel ? extRise : tbRise);
   assign swTrig = wrCtrl1 & s.wData[`SQS_C1_TRIG] & ~s.contEn;
   assign trig = (swTrig | contTrig) & ~haltReq;
   assign lastBit = (s.phase == ST_CONVERT) && (s.bitIdx == 4'h0)
      && (s.cnt == 6'(`SQS_BIT_CYC - 1));
   assign finishing = (s.phase == ST_FINISH) && (s.cnt == 6'(`SQS_TAIL_CYC - 1));

   always_comb begin
      rdOk = 1'b1;
      rdVal = 8'h00;
      case (rIdx)
         `SQS_IDX_CTRL1: begin
            rdVal[`SQS_C1_CHLO +: 3] = s.channel;
            rdVal[`SQS_C1_DONE] = s.doneFlag;
            rdVal[`SQS_C1_BUSY] = (s.phase != ST_IDLE);
         end
         `SQS_IDX_CTRL2: begin
            rdVal[`SQS_C2_RESV] = 1'b1;
            rdVal[`SQS_C2_CONT] = s.contEn;
            rdVal[`SQS_C2_IRQEN] = s.irqEn;
            rdVal[`SQS_C2_CKSEL] = s.clkSel;
         end
         `SQS_IDX_RESLO: rdVal = s.result[7:0];
         `SQS_IDX_RESHI: rdVal = {6'h00, s.result[9:8]};
         `SQS_IDX_EVST: rdVal = {6'h00, s.evtStat};
         `SQS_IDX_EVMSK: rdVal = {6'h00, s.evtMask};
         default: rdOk = 1'b0;
      endcase
      if (axiReq.araddr[1:0] != 2'h0) begin
         rdOk = 1'b0;
         rdVal = 8'h00;
      end
   end

   always_comb begin
      n = s;
      // synchronisers for the pin and the comparator
      n.extS1 = extTrigPin;
      n.extS2 = s.extS1;
      n.extQ = s.extS2;
      n.compS1 = compBit;
      n.compS2 = s.compS1;
      // clearing restarts the period, so the next edge comes 128 counts after the clear
      if (tbClear) begin
         n.tbDiv = 8'h00;
      end else if (mainOscRun) begin
         n.tbDiv = s.tbDiv + 8'h01;
      end
      n.tbBitQ = s.tbDiv[`SQS_TB_BITS-1];
      // write address and data in either order
      if (awHs) begin
         n.awHave = 1'b1;
         n.awAddr = axiReq.awaddr;
      end
      if (wHs) begin
         n.wHave = 1'b1;
         n.wData = axiReq.wdata[7:0];
         n.wStrb0 = axiReq.wstrb[0];
      end
      if (wrEn) begin
         n.awHave = 1'b0;
         n.wHave = 1'b0;
         n.bValid = 1'b1;
         n.bResp = `SQS_RESP_OKAY;
         if (s.awAddr[1:0] != 2'h0 || wIdx < `SQS_IDX_CTRL1 || wIdx > `SQS_IDX_EVMSK) begin
            n.bResp = `SQS_RESP_SLVERR;
         end
      end else if (s.bValid && axiReq.bready) begin
         n.bValid = 1'b0;
      end
      if (arHs) begin
         n.rValid = 1'b1;
         n.rData = rdVal;
         n.rResp = rdOk ? `SQS_RESP_OKAY : `SQS_RESP_SLVERR;
      end else if (s.rValid && axiReq.rready) begin
         n.rValid = 1'b0;
      end
      // register writes; busy and the trigger bit store nothing
      if (wrCtrl1) begin
         n.channel = s.wData[`SQS_C1_CHLO +: 3];
         if (!s.wData[`SQS_C1_DONE]) begin
            n.doneFlag = 1'b0;
         end
      end
      if (wrOk && wIdx == `SQS_IDX_CTRL2) begin
         n.contEn = s.wData[`SQS_C2_CONT];
         n.irqEn = s.wData[`SQS_C2_IRQEN];
         n.clkSel = s.wData[`SQS_C2_CKSEL];
      end
      if (wrOk && wIdx == `SQS_IDX_RESLO) begin
         n.result[7:0] = s.wData;
      end
      if (wrOk && wIdx == `SQS_IDX_RESHI) begin
         n.result[9:8] = s.wData[1:0];
      end
      if (wrOk && wIdx == `SQS_IDX_EVST) begin
         n.evtStat = s.evtStat & ~s.wData[1:0];
      end
      if (wrOk && wIdx == `SQS_IDX_EVMSK) begin
         n.evtMask = s.wData[1:0];
      end
      // conversion sequence
      case (s.phase)
         ST_IDLE: begin
         end
         ST_SAMPLE: begin
            n.cnt = s.cnt + 6'h01;
            if (s.cnt == 6'(`SQS_SAMPLE_CYC - 1)) begin
               n.phase = ST_CONVERT;
               n.cnt = 6'h00;
            end
         end
         ST_CONVERT: begin
            n.cnt = s.cnt + 6'h01;
            if (s.cnt == 6'(`SQS_BIT_CYC - 1)) begin
               n.cnt = 6'h00;
               // decided bit goes straight to the result
               n.result[s.bitIdx] = s.compS2;
               n.trial[s.bitIdx] = s.compS2;
               if (lastBit) begin
                  n.phase = ST_FINISH;
               end else begin
                  n.trial[s.bitIdx - 4'h1] = 1'b1;
                  n.bitIdx = s.bitIdx - 4'h1;
               end
            end
         end
         ST_FINISH: begin
            n.cnt = s.cnt + 6'h01;
            if (finishing) begin
               n.phase = ST_IDLE;
               n.cnt = 6'h00;
               n.evtStat[`SQS_EV_DONE] = 1'b1;
               if (!trig) begin
                  n.doneFlag = 1'b1;
               end
            end
         end
         default: begin
            n.phase = ST_IDLE;
         end
      endcase
      // any trigger aborts and restarts from sampling
      if (trig) begin
         if (s.phase != ST_IDLE && !finishing) begin
            n.evtStat[`SQS_EV_RETRIG] = 1'b1;
         end
         n.phase = ST_SAMPLE;
         n.cnt = 6'h00;
         n.bitIdx = 4'h9;
         n.trial = 10'h200;
         n.result = 10'h000;
      end
      if (haltReq) begin
         n.phase = ST_IDLE;
         n.cnt = 6'h00;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
         s.phase <= ST_IDLE;
         s.channel <= `SQS_RST_CHAN;
         s.evtMask <= `SQS_RST_EVMSK;
      end else begin
         s <= n;
      end
   end

   always_comb begin
      axiRsp = '0;
      axiRsp.awready = ~s.awHave & ~s.bValid;
      axiRsp.wready = ~s.wHave & ~s.bValid;
      axiRsp.bvalid = s.bValid;
      axiRsp.bresp = s.bResp;
      axiRsp.arready = ~s.rValid;
      axiRsp.rvalid = s.rValid;
      axiRsp.rdata = {24'h000000, s.rData};
      axiRsp.rresp = s.rResp;
   end

   assign channelSel = s.channel;
   assign trialCode = s.trial;
   assign sampleConnect = (s.phase == ST_SAMPLE);
   // done flag level keeps the request up until software clears it
   assign convIrqLine = (s.doneFlag & s.irqEn) | (|(s.evtStat & s.evtMask));

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sample_end_a: assert property (
      (s.phase == ST_SAMPLE && s.cnt == 6'h0f && !trig && !haltReq)
      |=> (s.phase == ST_CONVERT && !sampleConnect))
      else $error("sample window length wrong");

   halt_stops_a: assert property (
      haltReq |=> (s.phase == ST_IDLE) ##1 (s.phase == ST_IDLE || $past(trig)))
      else $error("halt did not stop conversion");

   retrig_done_a: assert property (
      (finishing && trig && !s.doneFlag) |=> !s.doneFlag && s.phase == ST_SAMPLE)
      else $error("done set despite retrigger");

   irq_level_a: assert property (
      (s.doneFlag && s.irqEn) |-> convIrqLine)
      else $error("irq dropped while done enabled");

   tb_frozen_a: assert property (
      (!mainOscRun && !tbClear) |=> $stable(s.tbDiv) && !tbRise)
      else $error("timebase moved with oscillator off");

   result_map_a: assert property (
      (arHs && axiReq.araddr == {`SQS_IDX_RESHI, 2'b00})
      |=> (axiRsp.rdata == {30'h0, $past(s.result[9:8])}))
      else $error("upper result bits misplaced");

   busy_done_a: assert property (
      (finishing && !trig && !haltReq) |=> s.doneFlag && s.phase == ST_IDLE)
      else $error("completion flags wrong");

   zero_write_a: assert property (
      (wrCtrl1 && s.wData == 8'h00 && !finishing)
      |=> s.channel == 3'h0 && !s.doneFlag && (s.phase == $past(s.phase) || $past(haltReq)
         || $past(contTrig) || $past(s.phase) != ST_IDLE))
      else $error("zero write misbehaved");

   cont_ignores_a: assert property (
      (wrCtrl1 && s.wData[`SQS_C1_TRIG] && s.contEn && !contTrig && s.phase == ST_IDLE)
      |=> s.phase == ST_IDLE)
      else $error("software trigger taken in continuous mode");

   trig_read0_a: assert property (
      (arHs && axiReq.araddr == 8'hd0) |=> axiRsp.rvalid && !axiRsp.rdata[0])
      else $error("trigger bit read as one");

   restart_a: assert property (
      (trig && s.phase == ST_CONVERT) |=> s.phase == ST_SAMPLE && s.cnt == 6'h00
         && s.bitIdx == 4'h9 && s.trial == 10'h200
         && s.evtStat[`SQS_EV_RETRIG])
      else $error("retrigger did not restart");

   // a further trigger or halt inside the window legally cuts it short
   restart_window_a: assert property (
      (trig && s.phase == ST_CONVERT) ##1 (!trig && !haltReq)[*8]
         ##1 (!trig && !haltReq)[*8]
      |=> s.phase == ST_CONVERT && s.cnt == 6'h00)
      else $error("restarted sample window wrong");

   sample_start_a: assert property (
      trig |=> sampleConnect && trialCode == 10'h200)
      else $error("sampling did not start");

   done_clear_a: assert property (
      (wrCtrl1 && !s.wData[`SQS_C1_DONE] && !finishing) |=> !s.doneFlag)
      else $error("done not cleared by zero write");

   done_keep_a: assert property (
      (wrCtrl1 && s.wData[`SQS_C1_DONE] && s.doneFlag) |=> s.doneFlag)
      else $error("done cleared by one write");

   cont_edge_a: assert property (
      (contTrig && !haltReq) |=> s.phase == ST_SAMPLE && s.cnt == 6'h00)
      else $error("continuous edge did not start");

   result_kept_a: assert property (
      (s.phase == ST_IDLE && !trig && !(wrOk && (wIdx == `SQS_IDX_RESLO
         || wIdx == `SQS_IDX_RESHI))) |=> $stable(s.result))
      else $error("idle result changed");

   msb_first_a: assert property (
      (s.phase == ST_CONVERT && s.bitIdx == 4'h9 && s.cnt == 6'(`SQS_BIT_CYC - 1)
         && !trig && !haltReq)
      |=> s.result[9] == $past(s.compS2) && s.trial[9:8] == {$past(s.compS2), 1'b1})
      else $error("top bit not decided first");

   irq_off_a: assert property (
      (!(s.doneFlag && s.irqEn) && (s.evtStat & s.evtMask) == 2'h0) |-> !convIrqLine)
      else $error("irq raised with nothing pending");
endmodule : sqs_conv_seq

// ### sqs_adc_model.sv
module sqs_adc_model (
   // clock
   input wire logic clk,
   // front end
   input wire logic [2:0] channelSel,
   input wire logic sampleConnect,
   input wire logic [9:0] trialCode,
   input wire logic [79:0] vin,
   // comparator
   output logic compBit
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] held = 10'h000;
   // capacitor follows the input only while connected
   always @(posedge clk) begin
      if (sampleConnect) begin
         held <= vin[channelSel * 10 +: 10];
      end
   end
   // keep the trial bit while the held input is not below it
   assign compBit = held >= trialCode;
endmodule : sqs_adc_model

// ### tb_top.sv
`include "sqs_params.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import sqs_pkg::*;
   localparam logic [7:0] AC1 = {`SQS_IDX_CTRL1, 2'b00};
   localparam logic [7:0] AC2 = {`SQS_IDX_CTRL2, 2'b00};
   localparam logic [7:0] ALO = {`SQS_IDX_RESLO, 2'b00};
   localparam logic [7:0] AHI = {`SQS_IDX_RESHI, 2'b00};
   localparam logic [7:0] AES = {`SQS_IDX_EVST, 2'b00};
   localparam logic [7:0] AEM = {`SQS_IDX_EVMSK, 2'b00};
   logic clk = 1'b0;
   logic resetn = 1'b0;
   sqs_axi_req_t req = '0;
   sqs_axi_rsp_t rsp;
   logic [2:0] channelSel;
   logic sampleConnect;
   logic compBit;
   logic convIrqLine;
   logic [9:0] trialCode;
   logic extTrigPin = 1'b0;
   logic mainOscRun = 1'b1;
   logic haltReq = 1'b0;
   logic tbClear = 1'b0;
   logic [79:0] vin = 80'h0;
   int errors = 0;
   int tests_run = 0;
   int run = 0;
   int spLen = 0;
   always #10 clk = ~clk;
   // length of the last connect window, sampled mid-cycle to dodge edge races
   always @(negedge clk) begin
      if (sampleConnect) begin
         run <= run + 1;
      end else if (run != 0) begin
         spLen <= run;
         run <= 0;
      end
   end
   sqs_conv_seq u_sqs_conv_seq (.clk(clk), .resetn(resetn), .axiReq(req), .axiRsp(rsp),
      .channelSel(channelSel), .sampleConnect(sampleConnect), .trialCode(trialCode),
      .compBit(compBit), .extTrigPin(extTrigPin), .mainOscRun(mainOscRun), .tbClear(tbClear),
      .haltReq(haltReq), .convIrqLine(convIrqLine));
   sqs_adc_model u_sqs_adc_model (.clk(clk), .channelSel(channelSel),
      .sampleConnect(sampleConnect), .trialCode(trialCode), .vin(vin), .compBit(compBit));
   task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", s, exp, seen);
      end
   endtask : check
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : summarize
   task automatic tmo();
      errors++;
      summarize();
   endtask : tmo
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   // ready and valid sampled mid-cycle, equal to their values at the next edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw;
      logic w;
      logic b;
      int i;
      b = 1'b0;
      req.awaddr <= a;
      req.wdata <= d;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      for (i = 0; i < 40 && !b; i++) begin
         @(negedge clk);
         aw = rsp.awready;
         w = rsp.wready;
         b = rsp.bvalid;
         r = rsp.bresp;
         @(posedge clk);
         if (aw) req.awvalid <= 1'b0;
         if (w) req.wvalid <= 1'b0;
      end
      if (!b) tmo();
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar;
      logic v;
      int i;
      v = 1'b0;
      req.araddr <= a;
      req.arvalid <= 1'b1;
      for (i = 0; i < 40 && !v; i++) begin
         @(negedge clk);
         ar = rsp.arready;
         v = rsp.rvalid;
         d = rsp.rdata;
         r = rsp.rresp;
         @(posedge clk);
         if (ar) req.arvalid <= 1'b0;
      end
      if (!v) tmo();
   endtask : rd
   task automatic waitIdle(output logic [31:0] d);
      logic [1:0] r;
      int i;
      for (i = 0; i < 60; i++) begin
         rd(AC1, d, r);
         if (d[2] === 1'b0) break;
      end
      if (i == 60) tmo();
   endtask : waitIdle
   task automatic toIrq(output int n);
      for (n = 1; n < 100; n++) begin
         @(posedge clk);
         #1;
         if (convIrqLine === 1'b1) break;
      end
      @(posedge clk);
   endtask : toIrq
   task automatic chkIrq(input logic e);
      @(negedge clk);
      check("irq", convIrqLine, e);
      @(posedge clk);
   endtask : chkIrq
   task automatic waitSp(input int lim);
      int i;
      for (i = 0; i < lim; i++) begin
         @(negedge clk);
         if (sampleConnect === 1'b1) break;
      end
      @(posedge clk);
      check("start seen", i < lim, 1'b1);
   endtask : waitSp
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [12:0] rows [4];
      int n;
      // channel beside the input value, which is also the expected result
      rows = '{13'h0000, 13'h1fff, 13'h0e00, 13'h1555};
      req.wstrb <= 4'hf;
      req.bready <= 1'b1;
      req.rready <= 1'b1;
      tick(16);
      resetn <= 1'b1;
      rd(AC1, d, r);
      check("ctrl1 reset", d, 32'h0);
      rd(AC2, d, r);
      check("ctrl2 reset", d, 32'h1);
      rd(AEM, d, r);
      check("mask reset", d, 32'h0);
      rd(8'h00, d, r);
      check("unmapped", r, `SQS_RESP_SLVERR);
      wr(8'hd1, 32'h1, r);
      check("unaligned", r, `SQS_RESP_SLVERR);
      $display("test reset finished");
      for (int k = 0; k < 4; k++) begin
         vin[rows[k][12:10] * 10 +: 10] <= rows[k][9:0];
         wr(AC1, {25'h0, rows[k][12:10], 4'h1}, r);
         waitIdle(d);
         check("done", d[3], 1'b1);
         check("channel", channelSel, rows[k][12:10]);
         rd(ALO, d, r);
         check("low byte", d, {24'h0, rows[k][7:0]});
         rd(AHI, d, r);
         check("high bits", d, {30'h0, rows[k][9:8]});
         wr(AC1, {25'h0, rows[k][12:10], 4'h8}, r);
         rd(AC1, d, r);
         check("done kept", d[3], 1'b1);
         wr(AC1, {25'h0, rows[k][12:10], 4'h0}, r);
         rd(AC1, d, r);
         check("done cleared", d, {25'h0, rows[k][12:10], 4'h0});
         rd(ALO, d, r);
         check("low kept", d, {24'h0, rows[k][7:0]});
      end
      $display("test rows finished");
      wr(AC2, 32'h9, r);
      wr(AC1, 32'h1, r);
      toIrq(n);
      check("latency", n, `SQS_SAMPLE_CYC + 10 * `SQS_BIT_CYC + `SQS_TAIL_CYC - 1);
      check("sample length", spLen, 16);
      tick(5);
      chkIrq(1'b1);
      wr(AC1, 32'h8, r);
      chkIrq(1'b1);
      wr(AC1, 32'h0, r);
      chkIrq(1'b0);
      wr(AC2, 32'h1, r);
      wr(AC1, 32'h1, r);
      waitIdle(d);
      chkIrq(1'b0);
      wr(AC2, 32'h9, r);
      chkIrq(1'b1);
      wr(AC1, 32'h0, r);
      wr(AC2, 32'h1, r);
      wr(AEM, 32'h1, r);
      chkIrq(1'b1);
      wr(AES, 32'h1, r);
      chkIrq(1'b0);
      $display("test irq finished");
      wr(AC1, 32'h1, r);
      tick(30);
      wr(AC1, 32'h1, r);
      toIrq(n);
      check("restart latency", n, `SQS_SAMPLE_CYC + 10 * `SQS_BIT_CYC + `SQS_TAIL_CYC - 1);
      rd(AES, d, r);
      check("events", d, 32'h3);
      wr(AES, 32'h3, r);
      wr(AEM, 32'h0, r);
      wr(AC1, 32'h0, r);
      // second trigger lands on the completion edge of the first
      wr(AC1, 32'h1, r);
      tick(`SQS_SAMPLE_CYC + 10 * `SQS_BIT_CYC + `SQS_TAIL_CYC - 3);
      wr(AC1, 32'h1, r);
      rd(AC1, d, r);
      check("retrig at end", d[3:2], 2'b01);
      rd(AES, d, r);
      check("end events", d, 32'h1);
      waitIdle(d);
      check("done after restart", d[3], 1'b1);
      wr(AES, 32'h3, r);
      wr(AC1, 32'h0, r);
      wr(AC1, 32'h1, r);
      tick(10);
      haltReq <= 1'b1;
      tick(1);
      haltReq <= 1'b0;
      tick(70);
      rd(AC1, d, r);
      check("halted", d[3:2], 2'b00);
      wr(AC1, 32'h51, r);
      tick(20);
      resetn <= 1'b0;
      tick(2);
      resetn <= 1'b1;
      rd(AC1, d, r);
      check("reset mid-run", d, 32'h0);
      rd(AC2, d, r);
      check("ctrl2 after reset", d, 32'h1);
      $display("test restart and halt finished");
      wr(AC2, 32'h13, r);
      wr(AC1, 32'h1, r);
      rd(AC1, d, r);
      check("sw ignored", d[2], 1'b0);
      // one edge only, far apart from any other conversion
      extTrigPin <= 1'b1;
      waitSp(10);
      waitIdle(d);
      check("pin done", d[3], 1'b1);
      extTrigPin <= 1'b0;
      mainOscRun <= 1'b0;
      wr(AC1, 32'h0, r);
      wr(AC2, 32'h3, r);
      tick(600);
      rd(AC1, d, r);
      check("osc stopped", d[3:2], 2'b00);
      mainOscRun <= 1'b1;
      waitSp(300);
      waitIdle(d);
      wr(AC1, 32'h0, r);
      // a held clear keeps the divider from ever reaching its edge
      tbClear <= 1'b1;
      tick(300);
      rd(AC1, d, r);
      check("cleared timebase", d[3:2], 2'b00);
      tbClear <= 1'b0;
      waitSp(200);
      // continuous off and idle before any channel change
      wr(AC2, 32'h1, r);
      waitIdle(d);
      $display("test continuous finished");
      summarize();
   end
endmodule : tb_top
